// File: common/pmcm_pkg.sv
// shared constants for the power-mode and system-clock manager
// assumes a 32-bit avalon-mm slave at byte addresses, one core clock
package pmcm_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SRC_W = 2;
    localparam int NSRC = 4;
    // register byte offsets
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIM = 8'h04;
    localparam logic [7:0] OFS_MPD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RETAIN = 8'h10;
    // oscillator_control_register fields
    localparam int CTL_SRC_LSB = 0;
    localparam int CTL_IDLE = 2;
    localparam int CTL_MULT = 3;
    localparam int CTL_POST_LSB = 4;
    localparam int CTL_DOZE_LSB = 8;
    localparam int CTL_DOZE_EN = 11;
    localparam int CTL_DEEP_EN = 12;
    localparam logic [31:0] CTRL_MASK = 32'h00001f7f;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    // status fields
    localparam int ST_SRC_LSB = 0;
    localparam int ST_BUSY = 2;
    localparam int ST_STARTUP_DONE = 3;
    localparam int ST_DS_WAKE = 4;
    localparam int ST_TSE = 5;
    localparam int ST_WAKE_LSB = 8;
    // clock sources, index into the tick vector
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_SEC = 2'h3;
    // trim: +/-12 percent in 0.8 percent steps gives +/-15 codes
    localparam logic [4:0] TRIM_RST = 5'h00;
    localparam logic [4:0] TRIM_FORBIDDEN = 5'h10;
    localparam logic [4:0] TRIM_NEG_LIMIT = 5'h11;
    // timing
    localparam int STARTUP_OSC_PERIODS = 1024;
    localparam int INSTR_PERIODS = 4;
    localparam int WAKE_RESET_NS = 1000;
    localparam int WAKE_RESET_CYCLES = (WAKE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 8;
    // power_save_instruction operands
    localparam logic [1:0] PSAVE_SLEEP = 2'h0;
    localparam logic [1:0] PSAVE_IDLE = 2'h1;
    // wake source bits
    localparam int NUM_WAKE = 6;
    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_DEEP, MODE_WAKE} power_mode_e;
endpackage

// File: hdl/clock_source_switch.sv
// glitch-free hand-over between clock sources given as tick enables
// assumes each tick is a one-cycle pulse per source period
`timescale 1ns/1ps
`default_nettype none
module clock_source_switch (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [pmcm_pkg::NSRC-1:0] tick,
    input wire logic [pmcm_pkg::SRC_W-1:0] sel,
    output logic [pmcm_pkg::SRC_W-1:0] active,
    output logic sys_tick,
    output logic busy
);
    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_SYNC, SW_ARM} sw_state_e;
    sw_state_e state;
    logic [pmcm_pkg::SRC_W-1:0] target;

    // old period ends on its own tick, new one is joined on its second tick,
    // so the bridging gap is never shorter than a full new period
    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            state <= SW_RUN;
        end else begin
            unique case (state)
                SW_RUN: if (sel != active) state <= SW_DRAIN;
                SW_DRAIN: if (tick[active]) state <= SW_SYNC;
                SW_SYNC: if (tick[target]) state <= SW_ARM;
                SW_ARM: if (tick[target]) state <= SW_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            target <= pmcm_pkg::SRC_INT;
        end else if (state == SW_RUN) begin
            target <= sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            active <= pmcm_pkg::SRC_INT;
        end else if (state == SW_ARM && tick[target]) begin
            active <= target;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            sys_tick <= 1'b0;
        end else if (state == SW_RUN || state == SW_DRAIN) begin
            sys_tick <= tick[active];
        end else begin
            sys_tick <= state == SW_ARM && tick[target];
        end
    end

    assign busy = state != SW_RUN;

    a_switch_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == SW_SYNC && !restart |=> !sys_tick)
        else $error("tick passed while joining new source");
    c_switch_done: cover property (@(posedge core_clk) disable iff (!rst_n)
        state == SW_ARM ##1 state == SW_RUN);
endmodule
`default_nettype wire

// File: hdl/power_mode_clock_manager.sv
// power-mode and system-clock manager: source switching, trim, idle,
// doze, module power disable, deep sleep with retention and wake reset
// assumes oscillators arrive as tick enables synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_manager #(
    parameter int N_MODULES = 16,
    parameter int STARTUP_PERIODS = pmcm_pkg::STARTUP_OSC_PERIODS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic two_speed_start_enable,
    input wire logic cfg_source_ext,
    input wire logic int_fast_tick,
    input wire logic int_pll_tick,
    input wire logic int_slow_tick,
    input wire logic ext_osc_tick,
    input wire logic sec_osc_tick,
    input wire logic sleep_instr,
    input wire logic power_save_instr,
    input wire logic [1:0] power_save_operand,
    input wire logic periph_irq,
    input wire logic calendar_irq,
    input wire logic ulp_wake,
    input wire logic deep_watchdog_timeout,
    input wire logic external_interrupt_zero,
    input wire logic master_clear_n,
    input wire logic por_event,
    output logic sys_clk_en,
    output logic cpu_clk_en,
    output logic instr_clk_en,
    output logic periph_clk_en,
    output logic [4:0] trim_code,
    output logic core_power_on,
    output logic [N_MODULES-1:0] periph_power_on,
    output logic flash_power_on,
    output logic sram_power_on,
    output logic supervisor_power_on,
    output logic keep_alive_power,
    output logic sec_osc_keep,
    output logic io_hold,
    output logic core_reset_n
);
    localparam logic [31:0] MPD_MASK = 32'((64'h1 << N_MODULES) - 64'h1);
    localparam int STARTUP_W = $clog2(STARTUP_PERIODS + 1);
    localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(STARTUP_PERIODS - 1);
    localparam logic [pmcm_pkg::WAKE_CNT_W-1:0] WAKE_LOAD =
        pmcm_pkg::WAKE_CNT_W'(pmcm_pkg::WAKE_RESET_CYCLES - 1);
    localparam logic [1:0] INSTR_LAST = 2'(pmcm_pkg::INSTR_PERIODS - 1);

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        be_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) be_merge[8*b +: 8] = wd[8*b +: 8];
        end
    endfunction

    function automatic logic [6:0] ratio_mask(input logic [2:0] r);
        ratio_mask = 7'((8'h01 << r) - 8'h01);
    endfunction

    pmcm_pkg::power_mode_e mode;
    logic [31:0] ctrl, mpd, retain, rd_word;
    logic [4:0] trim;
    logic tse, strap_pending, startup_done, ds_wake, busy, sys_tick, run_ok, cpu_t;
    logic [STARTUP_W-1:0] startup_cnt;
    logic [pmcm_pkg::WAKE_CNT_W-1:0] wake_cnt;
    logic [pmcm_pkg::NUM_WAKE-1:0] wake_vec, wake_src;
    logic [6:0] post_cnt, doze_cnt, post_mask, doze_mask;
    logic [1:0] instr_cnt, ctl_src, sel_req, active_src;
    logic int_src_tick, post_tick, wait_startup, clock_hold, doze_hit, wr_hit, wake_any;
    logic [pmcm_pkg::NSRC-1:0] ticks;

    assign ctl_src = ctrl[pmcm_pkg::CTL_SRC_LSB +: 2];
    assign post_mask = ratio_mask(ctrl[pmcm_pkg::CTL_POST_LSB +: 3]);
    assign doze_mask = ratio_mask(ctrl[pmcm_pkg::CTL_DOZE_LSB +: 3]);
    assign wr_hit = avs_write && !avs_waitrequest && mode != pmcm_pkg::MODE_WAKE;
    assign wake_vec = {por_event, !master_clear_n, external_interrupt_zero, deep_watchdog_timeout,
                       ulp_wake, calendar_irq};
    assign wake_any = |wake_vec;

    // register bus: one wait state; read data is loaded as waitrequest drops, the write lands at the edge ending the low cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_word : 32'h0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_word = 32'h0;
        unique case (avs_address)
            pmcm_pkg::OFS_OSC_CTRL: rd_word = ctrl;
            pmcm_pkg::OFS_TRIM: rd_word = {{27{trim[4]}}, trim};
            pmcm_pkg::OFS_MPD: rd_word = mpd;
            pmcm_pkg::OFS_RETAIN: rd_word = retain;
            pmcm_pkg::OFS_STATUS: begin
                rd_word[pmcm_pkg::ST_SRC_LSB +: 2] = active_src;
                rd_word[pmcm_pkg::ST_BUSY] = busy;
                rd_word[pmcm_pkg::ST_STARTUP_DONE] = startup_done;
                rd_word[pmcm_pkg::ST_DS_WAKE] = ds_wake;
                rd_word[pmcm_pkg::ST_TSE] = tse;
                rd_word[pmcm_pkg::ST_WAKE_LSB +: pmcm_pkg::NUM_WAKE] = wake_src;
            end
            default: rd_word = 32'h0;
        endcase
    end

    // config straps are caught one cycle after reset or wake release
    always_ff @(posedge core_clk) begin
        if (!rst_n || mode == pmcm_pkg::MODE_WAKE) begin
            strap_pending <= 1'b1;
        end else begin
            strap_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tse <= 1'b0;
        end else if (strap_pending && mode != pmcm_pkg::MODE_WAKE) begin
            tse <= two_speed_start_enable;
        end
    end

    // wake behaves as reset for control state, retention excepted
    always_ff @(posedge core_clk) begin
        if (!rst_n || mode == pmcm_pkg::MODE_WAKE) begin
            ctrl <= pmcm_pkg::CTRL_RST;
        end else if (strap_pending && cfg_source_ext) begin
            ctrl[pmcm_pkg::CTL_SRC_LSB +: 2] <= pmcm_pkg::SRC_EXT;
        end else if (wr_hit && avs_address == pmcm_pkg::OFS_OSC_CTRL) begin
            ctrl <= be_merge(ctrl, avs_writedata, avs_byteenable) & pmcm_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || mode == pmcm_pkg::MODE_WAKE) begin
            trim <= pmcm_pkg::TRIM_RST;
        end else if (wr_hit && avs_address == pmcm_pkg::OFS_TRIM && avs_byteenable[0]) begin
            // -16 has no matching step, so it saturates to -15
            trim <= (avs_writedata[4:0] == pmcm_pkg::TRIM_FORBIDDEN) ?
                    pmcm_pkg::TRIM_NEG_LIMIT : avs_writedata[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || mode == pmcm_pkg::MODE_WAKE) begin
            mpd <= 32'h0;
        end else if (wr_hit && avs_address == pmcm_pkg::OFS_MPD) begin
            mpd <= be_merge(mpd, avs_writedata, avs_byteenable) & MPD_MASK;
        end
    end

    // only a power-on reset clears retention; wake leaves it alone
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            retain <= 32'h0;
        end else if (wr_hit && avs_address == pmcm_pkg::OFS_RETAIN) begin
            retain <= be_merge(retain, avs_writedata, avs_byteenable);
        end
    end

    // set on a deep-sleep wake beats a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ds_wake <= 1'b0;
            wake_src <= '0;
        end else if (mode == pmcm_pkg::MODE_DEEP && wake_any) begin
            ds_wake <= 1'b1;
            wake_src <= wake_vec;
        end else if (wr_hit && avs_address == pmcm_pkg::OFS_STATUS && avs_byteenable[0]
                     && avs_writedata[pmcm_pkg::ST_DS_WAKE]) begin
            ds_wake <= 1'b0;
            wake_src <= '0;
        end
    end

    // start-up timer counts crystal periods; crystal is off in deep sleep
    always_ff @(posedge core_clk) begin
        if (!rst_n || mode == pmcm_pkg::MODE_DEEP) begin
            startup_cnt <= '0;
            startup_done <= 1'b0;
        end else if (!startup_done && ext_osc_tick) begin
            startup_cnt <= startup_cnt + STARTUP_W'(1);
            startup_done <= startup_cnt == STARTUP_LAST;
        end
    end

    assign wait_startup = ctl_src == pmcm_pkg::SRC_EXT && !startup_done;
    assign sel_req = wait_startup ? pmcm_pkg::SRC_INT : ctl_src;
    assign clock_hold = wait_startup && !tse;

    // multiplier picks the pll tick, postscaler divides by 2^n
    assign int_src_tick = ctrl[pmcm_pkg::CTL_MULT] ? int_pll_tick : int_fast_tick;
    assign post_tick = int_src_tick && ((post_cnt & post_mask) == post_mask);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            post_cnt <= 7'h00;
        end else if (int_src_tick) begin
            post_cnt <= post_cnt + 7'h01;
        end
    end

    assign ticks = {sec_osc_tick, ext_osc_tick, int_slow_tick, post_tick};

    clock_source_switch u_switch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(mode == pmcm_pkg::MODE_DEEP),
        .tick(ticks),
        .sel(sel_req),
        .active(active_src),
        .sys_tick(sys_tick),
        .busy(busy)
    );

    assign run_ok = sys_tick && !clock_hold && mode != pmcm_pkg::MODE_DEEP;
    assign doze_hit = !ctrl[pmcm_pkg::CTL_DOZE_EN] || ((doze_cnt & doze_mask) == doze_mask);
    assign cpu_t = run_ok && mode == pmcm_pkg::MODE_RUN && doze_hit;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            doze_cnt <= 7'h00;
        end else if (run_ok) begin
            doze_cnt <= doze_cnt + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || mode != pmcm_pkg::MODE_RUN) begin
            instr_cnt <= 2'h0;
        end else if (cpu_t) begin
            instr_cnt <= instr_cnt + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sys_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            cpu_clk_en <= 1'b0;
            instr_clk_en <= 1'b0;
        end else begin
            sys_clk_en <= run_ok;
            periph_clk_en <= run_ok;
            cpu_clk_en <= cpu_t;
            instr_clk_en <= cpu_t && instr_cnt == INSTR_LAST;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trim_code <= pmcm_pkg::TRIM_RST;
        end else begin
            trim_code <= trim;
        end
    end

    // mode sequencer; sleep without idle or deep enable is ignored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode <= pmcm_pkg::MODE_RUN;
            wake_cnt <= '0;
        end else begin
            unique case (mode)
                pmcm_pkg::MODE_RUN: begin
                    if (sleep_instr && ctrl[pmcm_pkg::CTL_IDLE]) begin
                        mode <= pmcm_pkg::MODE_IDLE;
                    end else if (sleep_instr && ctrl[pmcm_pkg::CTL_DEEP_EN]) begin
                        mode <= pmcm_pkg::MODE_DEEP;
                    end else if (power_save_instr
                                 && power_save_operand == pmcm_pkg::PSAVE_IDLE) begin
                        mode <= pmcm_pkg::MODE_IDLE;
                    end else if (power_save_instr && ctrl[pmcm_pkg::CTL_DEEP_EN]
                                 && power_save_operand == pmcm_pkg::PSAVE_SLEEP) begin
                        mode <= pmcm_pkg::MODE_DEEP;
                    end
                end
                pmcm_pkg::MODE_IDLE: if (periph_irq) mode <= pmcm_pkg::MODE_RUN;
                pmcm_pkg::MODE_DEEP: begin
                    if (wake_any) begin
                        mode <= pmcm_pkg::MODE_WAKE;
                        wake_cnt <= WAKE_LOAD;
                    end
                end
                pmcm_pkg::MODE_WAKE: begin
                    if (wake_cnt == '0) mode <= pmcm_pkg::MODE_RUN;
                    else wake_cnt <= wake_cnt - pmcm_pkg::WAKE_CNT_W'(1);
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_power_on <= 1'b1;
            flash_power_on <= 1'b1;
            sram_power_on <= 1'b1;
            supervisor_power_on <= 1'b1;
            io_hold <= 1'b0;
            keep_alive_power <= 1'b1;
            sec_osc_keep <= 1'b1;
            core_reset_n <= 1'b0;
        end else begin
            core_power_on <= mode != pmcm_pkg::MODE_DEEP;
            flash_power_on <= mode != pmcm_pkg::MODE_DEEP;
            sram_power_on <= mode != pmcm_pkg::MODE_DEEP;
            supervisor_power_on <= mode != pmcm_pkg::MODE_DEEP;
            io_hold <= mode == pmcm_pkg::MODE_DEEP;
            keep_alive_power <= 1'b1;
            sec_osc_keep <= 1'b1;
            core_reset_n <= mode != pmcm_pkg::MODE_WAKE;
        end
    end

    for (genvar i = 0; i < N_MODULES; i++) begin : g_mod_power
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                periph_power_on[i] <= 1'b1;
            end else begin
                periph_power_on[i] <= !mpd[i] && mode != pmcm_pkg::MODE_DEEP;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_idle_cpu_stop: assert property (mode == pmcm_pkg::MODE_IDLE |=> !cpu_clk_en)
        else $error("processor clocked in idle");
    a_idle_irq_wake: assert property (mode == pmcm_pkg::MODE_IDLE && periph_irq
        |=> mode == pmcm_pkg::MODE_RUN)
        else $error("interrupt did not end idle");
    a_doze_gap: assert property (cpu_clk_en && ctrl[pmcm_pkg::CTL_DOZE_EN] && $stable(ctrl)
        && ctrl[pmcm_pkg::CTL_DOZE_LSB +: 3] != 3'h0 |=> !cpu_clk_en)
        else $error("doze let two processor ticks pass back to back");
    a_instr_four: assert property (instr_clk_en |=> !instr_clk_en [*3])
        else $error("instruction cycle shorter than four periods");
    a_mpd_off: assert property (mpd[0] |=> !periph_power_on[0])
        else $error("disabled module still powered");
    a_deep_power: assert property (mode == pmcm_pkg::MODE_DEEP |=> !core_power_on
        && !flash_power_on && !sram_power_on && !supervisor_power_on && io_hold
        && keep_alive_power && sec_osc_keep)
        else $error("deep sleep power state wrong");
    a_retain_hold: assert property (mode == pmcm_pkg::MODE_DEEP |=> $stable(retain))
        else $error("retention changed in deep sleep");
    a_wake_reset: assert property (mode == pmcm_pkg::MODE_DEEP && wake_any
        |=> mode == pmcm_pkg::MODE_WAKE && ds_wake ##1 !core_reset_n)
        else $error("wake event did not start core reset");
    a_wake_len: assert property ($fell(core_reset_n) |-> !core_reset_n [*8])
        else $error("wake reset too short");
    a_trim_range: assert property (trim_code != pmcm_pkg::TRIM_FORBIDDEN)
        else $error("trim outside fifteen steps");
    a_hold_no_tse: assert property (clock_hold |=> !sys_clk_en)
        else $error("clock ran before start-up timer without two-speed");

    c_idle_wake: cover property (mode == pmcm_pkg::MODE_IDLE ##1 mode == pmcm_pkg::MODE_RUN);
    c_deep_wake: cover property (mode == pmcm_pkg::MODE_WAKE ##1 mode == pmcm_pkg::MODE_RUN);
    c_ext_handover: cover property (active_src == pmcm_pkg::SRC_EXT && $changed(active_src));
    c_doze_tick: cover property (cpu_clk_en && ctrl[pmcm_pkg::CTL_DOZE_EN]);
endmodule
`default_nettype wire

// File: test/osc_tick_model.sv
// partner: oscillator ticks, one pulse per source period
// assumes one core clock; tick ratios are small stand-ins
`timescale 1ns/1ps
`default_nettype none
module osc_tick_model (
    input wire logic core_clk,
    output logic [4:0] tick
);
    logic [3:0] ph = 4'h0;
    always_ff @(posedge core_clk) ph <= ph + 4'h1;
    assign tick = {ph == 4'hf, ph[1:0] == 2'h2, ph[2:0] == 3'h3, 1'b1, ph[0]};
endmodule
`default_nettype wire

// File: test/tb_power_mode_clock_manager.sv
// bench: trim, power disable, doze, idle, source switch, deep-sleep wake, cold start
// assumes osc_tick_model feeds every oscillator tick
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_clock_manager;
    logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0] avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hf;
    logic two_speed_start_enable = 1'b1, cfg_source_ext = 1'b0, sleep_instr = 1'b0;
    logic power_save_instr = 1'b0, periph_irq = 1'b0, por_event, master_clear_n;
    logic external_interrupt_zero;
    logic deep_watchdog_timeout, ulp_wake, calendar_irq, sys_clk_en, cpu_clk_en, instr_clk_en;
    logic int_fast_tick, int_pll_tick, int_slow_tick, ext_osc_tick, sec_osc_tick, io_hold;
    logic periph_clk_en, core_power_on, flash_power_on, sram_power_on, supervisor_power_on;
    logic keep_alive_power, sec_osc_keep, core_reset_n;
    logic [1:0] power_save_operand = 2'h0;
    logic [4:0] tick, trim_code;
    logic [5:0] wk = 6'h0;
    logic [15:0] periph_power_on;
    int err_total = 0, checked = 0, n, c, p;
    assign {sec_osc_tick, ext_osc_tick, int_slow_tick, int_pll_tick, int_fast_tick} = tick;
    assign {por_event, master_clear_n, external_interrupt_zero} = wk[5:3] ^ 3'h2;
    assign {deep_watchdog_timeout, ulp_wake, calendar_irq} = wk[2:0];
    always #5 core_clk = ~core_clk;
    osc_tick_model osc (.core_clk, .tick);
    power_mode_clock_manager #(.STARTUP_PERIODS(8)) dut (.*);
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        err_total += int'(s !== e);
        if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bound(input int lim);
        err_total += int'(n >= lim);
        if (n >= lim) complete_run();
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        for (n = 0; n < 50 && (n == 0 || avs_waitrequest !== 1'b0); n++) @(posedge core_clk);
        bound(50);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic count(input int w);
        {n, c, p} = 96'h0;
        repeat (w) @(posedge core_clk)
            {n, c, p} = {n + cpu_clk_en, c + instr_clk_en, p + periph_clk_en};
    endtask
    task automatic t_run(input logic [2:0] k);
        bus(1'b1, 8'h04, 32'h10);
        bus(1'b0, 8'h04, 32'h0);
        check(q, 32'hfffffff1);
        check(trim_code, 32'h11);
        // bits above the module count must read back as zero
        bus(1'b1, 8'h08, 32'hffff0009);
        bus(1'b0, 8'h08, 32'h0);
        check(q, 32'h9);
        check(32'(periph_power_on), 32'hfff6);
        bus(1'b1, 8'h00, {20'h0, 1'b1, k, 8'h0});
        // divider may start mid-period, so let two slow periods pass
        repeat (4 << k) @(posedge core_clk);
        count(64 << k);
        check(n, 32);
        check(c, 8);
        check(p, 32 << k);
        $display("run done");
    endtask
    task automatic t_idle(input logic via);
        bus(1'b1, 8'h00, {29'h0, via, 2'h0});
        {sleep_instr, power_save_instr, power_save_operand} <= {via, !via, 2'h1};
        @(posedge core_clk);
        {sleep_instr, power_save_instr} <= 2'h0;
        repeat (4) @(posedge core_clk);
        count(40);
        check(n, 0);
        check(p, 20);
        periph_irq <= 1'b1;
        for (n = 0; n < 20 && cpu_clk_en !== 1'b1; n++) @(posedge core_clk);
        bound(20);
        periph_irq <= 1'b0;
        $display("idle done");
    endtask
    task automatic t_deep(input int i);
        bus(1'b1, 8'h10, 32'ha5c30f00 + i);
        bus(1'b1, 8'h00, 32'h1000);
        {sleep_instr, power_save_instr, power_save_operand} <= {i[0], !i[0], 2'h0};
        @(posedge core_clk);
        {sleep_instr, power_save_instr} <= 2'h0;
        repeat (3) @(posedge core_clk);
        check({core_power_on, flash_power_on}, 0);
        check({sram_power_on, supervisor_power_on}, 0);
        check({io_hold, keep_alive_power, sec_osc_keep}, 7);
        wk <= 6'(1 << i);
        repeat (3) @(posedge core_clk);
        wk <= 6'h0;
        check(core_reset_n, 0);
        for (n = 0; n < 200 && core_reset_n !== 1'b1; n++) @(posedge core_clk);
        bound(200);
        check({io_hold, core_power_on, flash_power_on, sram_power_on}, 32'h7);
        bus(1'b0, 8'h0c, 32'h0);
        check(q[13:8], 32'(1 << i));
        check(q[4], 1);
        bus(1'b0, 8'h10, 32'h0);
        check(q, 32'ha5c30f00 + i);
        // clear the wake flag so the next wake has to set it again
        bus(1'b1, 8'h0c, 32'h10);
        bus(1'b0, 8'h0c, 32'h0);
        check({q[13:8], q[4]}, 0);
        $display("deep done");
    endtask
    task automatic t_switch(input logic [31:0] w, input int per);
        bus(1'b1, 8'h00, w);
        for (c = 0; c < 40 && (c == 0 || q[2:0] !== {1'b0, w[1:0]}); c++) bus(1'b0, 8'h0c, 32'h0);
        n = c;
        bound(40);
        check(q[5:3], 3'h5);
        count(64);
        check(p, 64 / per);
        check(n, 64 / per);
        $display("switch done");
    endtask
    task automatic t_cold();
        rst_n <= 1'b0;
        {two_speed_start_enable, cfg_source_ext} <= 2'h1;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // no two-speed start: every clock waits for the start-up timer
        count(8);
        check(p, 0);
        check(n, 0);
        bus(1'b0, 8'h10, 32'h0);
        check(q, 0);
        for (c = 0; c < 40 && (c == 0 || q[2:0] !== 3'h2); c++) bus(1'b0, 8'h0c, 32'h0);
        n = c;
        bound(40);
        check(q[5], 0);
        count(64);
        check(p, 16);
        check(n, 16);
        $display("cold done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_run(3'h0);
        t_run(3'h7);
        t_idle(1'b1);
        t_idle(1'b0);
        t_switch(32'h2, 4);
        t_switch(32'h1, 8);
        t_switch(32'h3, 16);
        t_switch(32'h8, 1);
        t_switch(32'h28, 4);
        t_switch(32'h0, 2);
        for (int i = 0; i < 6; i++) t_deep(i);
        t_cold();
        complete_run();
    end
endmodule
`default_nettype wire
